// [pkg/eeprom_pkg.sv]
package eeprom_pkg;
  localparam int ADDR_W = 17;
  localparam int PAGE_BYTES = 256;
  localparam int GROUP_BYTES = 4;
  localparam int GROUPS_PER_PAGE = PAGE_BYTES / GROUP_BYTES;
  localparam int WORDS = (1 << ADDR_W) / GROUP_BYTES;
  localparam int ECC_W = 6;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam int LOCK_SELECT_POS = 2;
  localparam int LOCK_DATA_POS = 1;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [5:0] ECC_FIRST_POS = 6'h03;
  localparam int CLK_PERIOD_NS = 25;
  localparam int INTERNAL_WRITE_TIME_NS = 100000;
  localparam int INTERNAL_WRITE_CYCLES = INTERNAL_WRITE_TIME_NS / CLK_PERIOD_NS;

  typedef enum logic [2:0] {PH_IDLE, PH_DEVSEL, PH_ADDR_HI, PH_ADDR_LO, PH_WDATA, PH_RDATA} phase_type;

  typedef struct packed {
    logic rise;
    logic fall;
    logic start;
    logic stop;
    logic bit_val;
  } bus_event_type;

  typedef struct packed {
    logic chip_sel_high;
    logic chip_sel_low;
    logic write_inhibit;
    logic sda;
    logic scl;
  } pin_type;

  // hamming check bits over a four-byte group
  function automatic logic [5:0] ecc_check(input logic [31:0] d);
    logic [5:0] c;
    logic [5:0] pos;
    c = '0;
    pos = ECC_FIRST_POS;
    for (int i = 0; i < 32; i++) begin
      if (d[i]) c = c ^ pos;
      pos = pos + 6'h01;
      if ((pos & (pos - 6'h01)) == 6'h00) pos = pos + 6'h01;
    end
    return c;
  endfunction : ecc_check

  // flip the single bit named by the syndrome
  function automatic logic [31:0] ecc_fix(input logic [31:0] d, input logic [5:0] stored);
    logic [5:0] syn;
    logic [5:0] pos;
    logic [31:0] r;
    syn = ecc_check(d) ^ stored;
    pos = ECC_FIRST_POS;
    r = d;
    for (int i = 0; i < 32; i++) begin
      if (pos == syn) r[i] = ~r[i];
      pos = pos + 6'h01;
      if ((pos & (pos - 6'h01)) == 6'h00) pos = pos + 6'h01;
    end
    return r;
  endfunction : ecc_fix
endpackage : eeprom_pkg

// [verilog/eeprom_engine.sv]
`timescale 1ns/1ps
module eeprom_engine #(
  parameter logic [3:0] MEM_TYPE_ID = 4'hA, // arbitrary value
  parameter logic [3:0] ID_TYPE_ID = 4'hC, // arbitrary value
  parameter int WRITE_CYCLES = eeprom_pkg::INTERNAL_WRITE_CYCLES
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic write_inhibit_input_in,
  input wire logic chip_select_pin_low_in,
  input wire logic chip_select_pin_high_in,
  output logic sda_out,
  output logic sda_oe_out,
  output logic write_busy_out,
  output logic id_locked_out
);
  import eeprom_pkg::*;

  if (WRITE_CYCLES <= GROUPS_PER_PAGE) begin : g_bad_cycles
    $error("write cycle count too short for the group commit");
  end

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_n_in);

  ////////////////////////////////////////////////////////////////////////////
  // link side: capture the data bit on each clock rise
  logic link_bit;
  logic link_tog;
  logic next_link_tog;

  always_comb begin
    next_link_tog = ~link_tog;
  end

  always_ff @(posedge scl_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      link_bit <= 1'b0;
      link_tog <= 1'b0;
    end else begin
      link_bit <= sda_in;
      link_tog <= next_link_tog;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers and bus events
  pin_type pin_meta;
  pin_type pin_sync;
  pin_type pin_prev;
  logic tog_meta;
  logic tog_sync;
  logic tog_prev;
  pin_type pin_now;
  bus_event_type ev;

  always_comb begin
    pin_now = '{chip_sel_high: chip_select_pin_high_in, chip_sel_low: chip_select_pin_low_in,
                write_inhibit: write_inhibit_input_in, sda: sda_in, scl: scl_in};
    ev.rise = tog_sync ^ tog_prev;
    ev.bit_val = link_bit;
    ev.fall = pin_prev.scl & ~pin_sync.scl;
    ev.start = pin_sync.scl & pin_prev.scl & pin_prev.sda & ~pin_sync.sda;
    ev.stop = pin_sync.scl & pin_prev.scl & ~pin_prev.sda & pin_sync.sda;
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_meta <= '1;
      pin_sync <= '1;
      pin_prev <= '1;
      tog_meta <= 1'b0;
      tog_sync <= 1'b0;
      tog_prev <= 1'b0;
    end else begin
      pin_meta <= pin_now;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
      tog_meta <= link_tog;
      tog_sync <= tog_meta;
      tog_prev <= tog_sync;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // storage: array words with check bits, identification page, staging page
  // erased contents set at declaration, the write process alone owns the arrays
  localparam logic [ECC_W-1:0] ERASED_ECC = ecc_check({4{ERASED_BYTE}});
  logic [31:0] mem_data [WORDS] = '{default: {4{ERASED_BYTE}}};
  logic [ECC_W-1:0] mem_ecc [WORDS] = '{default: ERASED_ECC};
  logic [7:0] id_mem [PAGE_BYTES] = '{default: ERASED_BYTE};
  logic [7:0] stage_data [PAGE_BYTES];

  ////////////////////////////////////////////////////////////////////////////
  // command engine
  phase_type phase, next_phase;
  logic [3:0] bit_cnt, next_bit_cnt;
  logic [7:0] shreg, next_shreg;
  logic [7:0] tx, next_tx;
  logic [ADDR_W-1:0] addr_cnt, next_addr_cnt;
  logic [7:0] addr_hi, next_addr_hi;
  logic top_bit, next_top_bit;
  logic id_sel, next_id_sel;
  logic tenth, next_tenth;
  logic sda_oe, next_sda_oe;
  logic busy, next_busy;
  logic [6:0] commit_idx, next_commit_idx;
  logic [31:0] wait_cnt, next_wait_cnt;
  logic [PAGE_BYTES-1:0] stage_vld, next_stage_vld;
  logic [8:0] stage_page, next_stage_page;
  logic stage_id, next_stage_id;
  logic lock_pend, next_lock_pend;
  logic locked, next_locked;
  logic stage_we;
  logic commit_we;
  logic dev_match;
  logic lock_cmd;
  logic data_ok;
  logic [14:0] commit_word;
  logic [31:0] commit_old;
  logic [31:0] commit_new;
  logic [31:0] rd_word;
  logic [7:0] rd_byte;

  // corrected group read at the counter
  // single bit correction
  always_comb begin
    rd_word = ecc_fix(mem_data[addr_cnt[ADDR_W-1:2]], mem_ecc[addr_cnt[ADDR_W-1:2]]);
    rd_byte = id_sel ? id_mem[addr_cnt[7:0]] : rd_word[8*addr_cnt[1:0] +: 8];
    commit_word = {stage_page, commit_idx[5:0]};
    commit_old = ecc_fix(mem_data[commit_word], mem_ecc[commit_word]);
  end

  // whole group rewritten, untouched bytes kept
  for (genvar gb = 0; gb < GROUP_BYTES; gb++) begin : g_merge
    assign commit_new[8*gb +: 8] = stage_vld[{commit_idx[5:0], 2'(gb)}] ?
                                   stage_data[{commit_idx[5:0], 2'(gb)}] : commit_old[8*gb +: 8];
  end

  always_comb begin
    dev_match = (shreg[3:2] == {pin_sync.chip_sel_high, pin_sync.chip_sel_low}) &&
                (shreg[7:4] == MEM_TYPE_ID || shreg[7:4] == ID_TYPE_ID);
    lock_cmd = id_sel && addr_hi[LOCK_SELECT_POS];
    data_ok = !pin_sync.write_inhibit && !(id_sel && locked);
  end

  always_comb begin
    next_phase = phase;
    next_bit_cnt = bit_cnt;
    next_shreg = shreg;
    next_tx = tx;
    next_addr_cnt = addr_cnt;
    next_addr_hi = addr_hi;
    next_top_bit = top_bit;
    next_id_sel = id_sel;
    next_tenth = tenth;
    next_sda_oe = sda_oe;
    next_busy = busy;
    next_commit_idx = commit_idx;
    next_wait_cnt = wait_cnt;
    next_stage_vld = stage_vld;
    next_stage_page = stage_page;
    next_stage_id = stage_id;
    next_lock_pend = lock_pend;
    next_locked = locked;
    stage_we = 1'b0;
    commit_we = 1'b0;
    if (busy) begin
      next_phase = PH_IDLE;
      next_sda_oe = 1'b0;
      if (commit_idx < 7'(GROUPS_PER_PAGE)) begin
        commit_we = 1'b1;
        next_commit_idx = commit_idx + 7'h01;
      end
      next_wait_cnt = wait_cnt + 32'h0000_0001;
      if (wait_cnt == 32'(WRITE_CYCLES - 1)) begin
        next_busy = 1'b0;
        next_stage_vld = '0;
        if (lock_pend) next_locked = 1'b1;
        next_lock_pend = 1'b0;
      end
    end else if (ev.start) begin
      next_phase = PH_DEVSEL;
      next_bit_cnt = 4'h0;
      next_sda_oe = 1'b0;
      next_stage_vld = '0;
      next_lock_pend = 1'b0;
      next_tenth = 1'b0;
    end else if (ev.stop) begin
      // write only from the tenth slot
      if (tenth && phase == PH_WDATA && (|stage_vld || lock_pend)) begin
        next_busy = 1'b1;
        next_commit_idx = 7'h00;
        next_wait_cnt = 32'h0000_0000;
      end
      next_phase = PH_IDLE;
      next_sda_oe = 1'b0;
      next_tenth = 1'b0;
    end else if (phase != PH_IDLE && ev.rise) begin
      if (bit_cnt == ACK_SLOT) begin
        next_bit_cnt = 4'h0;
        next_tenth = (phase == PH_WDATA);
        if (phase == PH_RDATA && ev.bit_val) next_phase = PH_IDLE;
      end else begin
        next_shreg = {shreg[6:0], ev.bit_val};
        next_bit_cnt = bit_cnt + 4'h1;
      end
    end else if (phase != PH_IDLE && ev.fall) begin
      next_sda_oe = 1'b0;
      // tenth slot ends at its clock fall
      if (bit_cnt != 4'h0) next_tenth = 1'b0;
      if (bit_cnt == ACK_SLOT && phase != PH_RDATA) begin
        case (phase)
          PH_DEVSEL: begin
            if (dev_match) begin
              next_sda_oe = 1'b1;
              next_id_sel = (shreg[7:4] == ID_TYPE_ID);
              next_phase = shreg[0] ? PH_RDATA : PH_ADDR_HI;
              next_top_bit = shreg[1];
            end else begin
              next_phase = PH_IDLE;
            end
          end
          PH_ADDR_HI: begin
            next_addr_hi = shreg;
            next_sda_oe = 1'b1;
            next_phase = PH_ADDR_LO;
          end
          PH_ADDR_LO: begin
            next_sda_oe = 1'b1;
            next_phase = PH_WDATA;
            // id access loads the in-page location
            next_addr_cnt = id_sel ? {9'h000, shreg} : {top_bit, addr_hi, shreg};
            next_stage_page = {top_bit, addr_hi};
            next_stage_id = id_sel;
          end
          PH_WDATA: begin
            next_sda_oe = data_ok;
            if (data_ok && lock_cmd) begin
              if (shreg[LOCK_DATA_POS]) next_lock_pend = 1'b1;
            end else if (data_ok) begin
              stage_we = 1'b1;
              next_stage_vld[addr_cnt[7:0]] = 1'b1;
              next_addr_cnt[7:0] = addr_cnt[7:0] + 8'h01;
            end
          end
          default: next_phase = PH_IDLE;
        endcase
      end else if (phase == PH_RDATA && bit_cnt == 4'h0) begin
        next_tx = rd_byte;
        next_sda_oe = ~rd_byte[7];
        next_addr_cnt = addr_cnt + 17'h0_0001;
      end else if (phase == PH_RDATA && bit_cnt != ACK_SLOT) begin
        next_sda_oe = ~tx[3'(4'h7 - bit_cnt)];
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      phase <= PH_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      tx <= 8'h00;
      addr_cnt <= 17'h0_0000;
      addr_hi <= 8'h00;
      top_bit <= 1'b0;
      id_sel <= 1'b0;
      tenth <= 1'b0;
      sda_oe <= 1'b0;
      busy <= 1'b0;
      commit_idx <= 7'h00;
      wait_cnt <= 32'h0000_0000;
      stage_vld <= '0;
      stage_page <= 9'h000;
      stage_id <= 1'b0;
      lock_pend <= 1'b0;
      locked <= 1'b0;
    end else begin
      phase <= next_phase;
      bit_cnt <= next_bit_cnt;
      shreg <= next_shreg;
      tx <= next_tx;
      addr_cnt <= next_addr_cnt;
      addr_hi <= next_addr_hi;
      top_bit <= next_top_bit;
      id_sel <= next_id_sel;
      tenth <= next_tenth;
      sda_oe <= next_sda_oe;
      busy <= next_busy;
      commit_idx <= next_commit_idx;
      wait_cnt <= next_wait_cnt;
      stage_vld <= next_stage_vld;
      stage_page <= next_stage_page;
      stage_id <= next_stage_id;
      lock_pend <= next_lock_pend;
      locked <= next_locked;
    end
  end

  // memory writes, one group per cycle during the write
  always_ff @(posedge clk_sys_in) begin
    if (stage_we) stage_data[addr_cnt[7:0]] <= shreg;
    if (commit_we && !stage_id) begin
      mem_data[commit_word] <= commit_new;
      mem_ecc[commit_word] <= ecc_check(commit_new);
    end
    for (int b = 0; b < GROUP_BYTES; b++) begin
      if (commit_we && stage_id && stage_vld[{commit_idx[5:0], 2'(b)}]) begin
        id_mem[{commit_idx[5:0], 2'(b)}] <= stage_data[{commit_idx[5:0], 2'(b)}];
      end
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe_out = sda_oe;
  assign write_busy_out = busy;
  assign id_locked_out = locked;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  chk_busy_released: assert property (busy && $past(busy) |-> !sda_oe)
    else $error("data line driven during internal write");
  chk_inhibit_nack: assert property (
    !busy && !ev.start && !ev.stop && ev.fall && phase == PH_WDATA && bit_cnt == ACK_SLOT
    && pin_sync.write_inhibit |-> !stage_we ##1 !sda_oe && $stable(stage_vld))
    else $error("data acknowledged while inhibited");
  chk_stop_writes: assert property (
    !busy && ev.stop && tenth && phase == PH_WDATA && |stage_vld |=> busy [*8])
    else $error("tenth slot stop did not start write");
  chk_stop_ignored: assert property (!busy && ev.stop && !tenth |=> !busy)
    else $error("stop outside tenth slot started write");
  chk_page_wrap: assert property (stage_we && addr_cnt[7:0] == 8'hFF |=>
    addr_cnt[7:0] == 8'h00 && addr_cnt[16:8] == $past(addr_cnt[16:8]))
    else $error("page roll-over wrong");
  chk_read_incr: assert property (
    !busy && !ev.start && !ev.stop && ev.fall && phase == PH_RDATA && bit_cnt == 4'h0
    |=> addr_cnt == $past(addr_cnt) + 17'h0_0001)
    else $error("read counter not advanced");
  chk_nack_standby: assert property (
    !busy && !ev.start && !ev.stop && ev.rise && phase == PH_RDATA && bit_cnt == ACK_SLOT
    && ev.bit_val |=> phase == PH_IDLE ##[1:3] !sda_oe)
    else $error("no standby after master nack");
  chk_select_ack: assert property (
    !busy && !ev.start && !ev.stop && ev.fall && phase == PH_DEVSEL && bit_cnt == ACK_SLOT
    |=> sda_oe == $past(dev_match))
    else $error("select byte answer wrong");
  chk_lock_nack: assert property (
    !busy && !ev.start && !ev.stop && ev.fall && phase == PH_WDATA && bit_cnt == ACK_SLOT
    && id_sel && locked |=> !sda_oe && $stable(stage_vld))
    else $error("locked page accepted data");
endmodule : eeprom_engine

// [verif/i2c_master_model.sv]
`timescale 1ns/1ps
module i2c_master_model (
  input wire logic dev_pull_in,
  output logic scl_out,
  output logic sda_out
);
  logic drv_low;
  // open drain wire with pull-up
  assign sda_out = !(drv_low || dev_pull_in);
  initial begin
    scl_out = 1'b1;
    drv_low = 1'b0;
  end
  ////////////////////////////////////////
  // start or repeated start, clock left low
  task automatic start();
    if (!scl_out) begin
      #80 drv_low = 1'b0;
      #32 scl_out = 1'b1;
    end
    #100 drv_low = 1'b1;
    #100 scl_out = 1'b0;
  endtask : start
  task automatic stop();
    #80 drv_low = 1'b1;
    #32 scl_out = 1'b1;
    #100 drv_low = 1'b0;
    #100;
  endtask : stop
  // data changes only while the clock is low
  task automatic bit_slot(input logic b, output logic seen);
    #80 drv_low = !b;
    #32 scl_out = 1'b1;
    seen = sda_out;
    #48 scl_out = 1'b0;
  endtask : bit_slot
  ////////////////////////////////////////
  // msb first
  task automatic send(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_slot(b[i], s);
    bit_slot(1'b1, s);
    ack = !s;
  endtask : send
  task automatic recv(input logic ack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_slot(1'b1, s);
      b[i] = s;
    end
    bit_slot(!ack, s);
  endtask : recv
endmodule : i2c_master_model

// [verif/tb_i2c_eeprom_command_engine.sv]
`timescale 1ns/1ps
`define chk(nm, exp, got) begin checks++; if ((got) !== (exp)) begin mismatches++; \
  $display("MISMATCH %s expected %h seen %h", nm, exp, got); end end
module tb_i2c_eeprom_command_engine;
  import eeprom_pkg::*;
  localparam logic [3:0] MEM_ID = 4'h5; // arbitrary value
  localparam logic [3:0] ID_ID = 4'h9; // arbitrary value
  localparam logic [1:0] CS = 2'b10;
  typedef struct packed {logic [16:0] addr; logic [7:0] data;} row_type;
  row_type rows [4] = '{'{17'h1_2345, 8'hA5}, '{17'h0_0006, 8'h5A}, '{17'h1_FFFF, 8'h3C}, '{17'h0_0000, 8'hC3}};
  logic clk_sys_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic inhibit = 1'b0;
  logic [1:0] cs = CS;
  logic scl, sda, sda_drv, oe, busy, locked, a;
  logic [7:0] d;
  int mismatches = 0;
  int checks = 0;
  always #12.5 clk_sys_in = ~clk_sys_in;
  eeprom_engine #(.MEM_TYPE_ID(MEM_ID), .ID_TYPE_ID(ID_ID), .WRITE_CYCLES(100)) dut (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .scl_in(scl), .sda_in(sda),
    .write_inhibit_input_in(inhibit), .chip_select_pin_low_in(cs[0]), .chip_select_pin_high_in(cs[1]),
    .sda_out(sda_drv), .sda_oe_out(oe), .write_busy_out(busy), .id_locked_out(locked));
  i2c_master_model master (.dev_pull_in(oe && !sda_drv), .scl_out(scl), .sda_out(sda));
  ////////////////////////////////////////
  function automatic logic [7:0] sel(input logic id, input logic top, input logic rd);
    return {id ? ID_ID : MEM_ID, CS, top, rd};
  endfunction : sel
  task automatic hdr(input logic id, input logic [16:0] ad);
    logic k;
    master.start();
    master.send(sel(id, ad[16], 1'b0), k);
    `chk("select ack", 1'b1, k)
    master.send(ad[15:8], k);
    `chk("addr hi ack", 1'b1, k)
    master.send(ad[7:0], k);
    `chk("addr lo ack", 1'b1, k)
  endtask : hdr
  task automatic rsel(input logic id, input logic top);
    logic k;
    master.start();
    master.send(sel(id, top, 1'b1), k);
    `chk("read select ack", 1'b1, k)
  endtask : rsel
  // poll until the write is done
  task automatic finish_write();
    logic k;
    int n;
    master.stop();
    repeat (4) @(posedge clk_sys_in);
    `chk("busy", 1'b1, busy)
    n = 0;
    k = 1'b0;
    while (!k && n < 40) begin
      master.start();
      master.send(sel(1'b0, 1'b0, 1'b0), k);
      if (n == 0) `chk("poll while busy", 1'b0, k)
      n++;
    end
    master.stop();
    `chk("poll done", 1'b1, k)
  endtask : finish_write
  task automatic no_write();
    repeat (6) @(posedge clk_sys_in);
  endtask : no_write
  task automatic results();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results
  ////////////////////////////////////////
  initial begin
    #1_000_000;
    mismatches++;
    results();
  end
  initial begin
    repeat (4) @(posedge clk_sys_in);
    #2 rst_n_in = 1'b1;
    `chk("busy after reset", 1'b0, busy)
    `chk("oe after reset", 1'b0, oe)
    `chk("locked after reset", 1'b0, locked)
    $display("reset test done");
    repeat (4) @(posedge clk_sys_in);
    foreach (rows[i]) begin
      hdr(1'b0, rows[i].addr);
      master.send(rows[i].data, a);
      `chk("data ack", 1'b1, a)
      finish_write();
      hdr(1'b0, rows[i].addr);
      rsel(1'b0, rows[i].addr[16]);
      master.recv(1'b0, d);
      master.stop();
      `chk("read back", rows[i].data, d)
      $display("row %0d done", i);
    end
    hdr(1'b0, 17'h1_23FE);
    for (int i = 0; i < 3; i++) begin
      master.send(8'(8'h10 + i), a);
      `chk("page ack", 1'b1, a)
    end
    finish_write();
    rsel(1'b0, 1'b1);
    master.recv(1'b0, d);
    master.stop();
    `chk("counter after write", 8'hFF, d)
    hdr(1'b0, 17'h1_23FE);
    rsel(1'b0, 1'b1);
    master.recv(1'b1, d);
    `chk("page byte 0", 8'h10, d)
    master.recv(1'b0, d);
    master.stop();
    `chk("page byte 1", 8'h11, d)
    hdr(1'b0, 17'h1_2300);
    rsel(1'b0, 1'b1);
    master.recv(1'b0, d);
    master.stop();
    `chk("page roll", 8'h12, d)
    hdr(1'b0, 17'h1_2344);
    rsel(1'b0, 1'b1);
    for (int i = 0; i < 3; i++) begin
      master.recv(i < 2, d);
      `chk("group neighbours", (i == 1) ? 8'hA5 : 8'hFF, d)
    end
    master.stop();
    hdr(1'b0, 17'h1_FFFF);
    rsel(1'b0, 1'b1);
    master.recv(1'b1, d);
    master.recv(1'b0, d);
    master.stop();
    `chk("counter wrap", 8'hC3, d)
    $display("page and sequential tests done");
    hdr(1'b1, 17'h1_9B05);
    master.send(8'h77, a);
    `chk("id data ack", 1'b1, a)
    finish_write();
    hdr(1'b1, 17'h0_0005);
    rsel(1'b1, 1'b0);
    master.recv(1'b0, d);
    master.stop();
    `chk("id read", 8'h77, d)
    rsel(1'b0, 1'b0);
    master.recv(1'b0, d);
    master.stop();
    `chk("shared counter", 8'h5A, d)
    hdr(1'b1, 17'h0_0010);
    master.send(8'h00, a);
    `chk("query unlocked", 1'b1, a)
    master.start();
    master.stop();
    no_write();
    `chk("query no write", 1'b0, busy)
    hdr(1'b1, 17'h0_0400);
    master.send(8'h02, a);
    `chk("lock ack", 1'b1, a)
    finish_write();
    `chk("locked", 1'b1, locked)
    hdr(1'b1, 17'h0_0005);
    master.send(8'h99, a);
    `chk("locked id data nack", 1'b0, a)
    master.stop();
    no_write();
    `chk("locked no write", 1'b0, busy)
    hdr(1'b1, 17'h0_0005);
    rsel(1'b1, 1'b0);
    master.recv(1'b0, d);
    master.stop();
    `chk("id unchanged", 8'h77, d)
    $display("id page tests done");
    @(posedge clk_sys_in);
    #2 inhibit = 1'b1;
    hdr(1'b0, 17'h1_2345);
    master.send(8'h00, a);
    `chk("inhibit nack", 1'b0, a)
    master.stop();
    no_write();
    `chk("inhibit no write", 1'b0, busy)
    hdr(1'b0, 17'h1_2345);
    rsel(1'b0, 1'b1);
    master.recv(1'b0, d);
    master.stop();
    `chk("read while inhibited", 8'hA5, d)
    @(posedge clk_sys_in);
    #2 inhibit = 1'b0;
    hdr(1'b0, 17'h0_0000);
    master.stop();
    no_write();
    `chk("stop in wrong slot", 1'b0, busy)
    hdr(1'b0, 17'h0_0000);
    master.send(8'h00, a);
    master.bit_slot(1'b1, a);
    master.stop();
    no_write();
    `chk("stop in eleventh slot", 1'b0, busy)
    @(posedge clk_sys_in);
    #2 cs = 2'b01;
    master.start();
    master.send(sel(1'b0, 1'b0, 1'b0), a);
    master.stop();
    `chk("chip select mismatch", 1'b0, a)
    @(posedge clk_sys_in);
    #2 cs = CS;
    $display("inhibit and select tests done");
    results();
  end
endmodule : tb_i2c_eeprom_command_engine
